// File: common/dasr_map.vh
// Constants for the differential converter serial readout block.
// Assumes inclusion by bare name from the design files.
`ifndef DASR_MAP_VH
`define DASR_MAP_VH
`define DASR_NULL_BITS    4
`define DASR_RESULT_BITS  12
`define DASR_FRAME_BITS   16
`define DASR_CNT_W        5
`define DASR_CNT_RST      5'h00
`define DASR_CNT_ONE      5'h01
`define DASR_CNT_LAST     5'h0F
`define DASR_SHIFT_RST    16'h0000
`define DASR_RESULT_RST   12'h000
`endif

// File: logic/dasr_sync.v
// Three-stage synchroniser for one pin input with agreement filter.
// Assumes the input is asynchronous to CLOCK_I; output changes only
// when the second and third stages agree.
module dasr_sync #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk_i,
  input  wire rst_i,
  input  wire pin_i,
  output reg  level_o
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  // Shift the pin through three stages and update the filtered level.
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg  <= RST_VAL;
      s2_reg  <= RST_VAL;
      s3_reg  <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule

// File: logic/dasr_top.v
// Serial readout and conversion control of a 12-bit differential converter.
// Assumes select and serial clock come from a host outside the CLOCK_I
// domain; the sample word arrives in parallel from the analog core.
// Each pin passes a three-stage filter, so a pin edge takes effect four
// to five CLOCK_I cycles after it arrives, and a data bit reaches its pin
// that long after the serial clock fall that calls for it.
// Assumes SAMPLE_I is steady from before select fall until it is taken.
// There is no register interface; all control comes from the pins.
// Operation
// - Select low runs, select high powers down.
// - Conversion starts at select falling edge.
// - Frame: four null bits, twelve bits, MSB first.
// - Output changes on serial clock falling edges.
// - Serial clock paces transfer and conversion.
// - Result is two's complement, MSB is sign.
`include "dasr_map.vh"
module dasr_top (
  input  wire        CLOCK_I,
  input  wire        SYS_RST_I,
  input  wire        CONV_SEL_N_I,
  input  wire        SER_CLK_I,
  input  wire [11:0] SAMPLE_I,
  output reg         SER_DATA_O,
  output reg         SER_DATA_OE_N_O,
  output reg         POWER_DOWN_O,
  output reg         CONV_BUSY_O,
  output reg         SAMPLE_HOLD_O
);
  // One-hot frame states: power-down, frame shifting, and frame
  // complete while waiting for select to rise.
  localparam ST_DOWN = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_DONE = 3'b100;

  // Filtered pins, edge strobes, frame state and the next values of
  // every output flip-flop.
  wire                         sel_n;
  wire                         sclk;
  wire                         sel_fall;
  wire                         sclk_fall;
  wire                         frame_load;
  wire                         frame_step;
  reg                          sel_n_d_reg;
  reg                          sclk_d_reg;
  reg  [2:0]                   state_reg;
  reg  [2:0]                   state_next;
  reg  [`DASR_CNT_W-1:0]       cnt_reg;
  reg  [`DASR_CNT_W-1:0]       cnt_next;
  reg  [`DASR_FRAME_BITS-1:0]  shift_reg;
  reg  [`DASR_FRAME_BITS-1:0]  shift_next;
  reg                          pd_next;
  reg                          busy_next;
  reg                          hold_next;
  reg                          oe_n_next;
  reg                          data_next;

  // Filtered copies of the select and serial clock pins. Select rests
  // high and the serial clock rests low, so each filter starts at the
  // idle level of its pin and reset never leaves a false edge behind.
  dasr_sync #(.RST_VAL(1'b1)) u_sel_sync (
    .clk_i   (CLOCK_I),
    .rst_i   (SYS_RST_I),
    .pin_i   (CONV_SEL_N_I),
    .level_o (sel_n)
  );
  dasr_sync #(.RST_VAL(1'b0)) u_sclk_sync (
    .clk_i   (CLOCK_I),
    .rst_i   (SYS_RST_I),
    .pin_i   (SER_CLK_I),
    .level_o (sclk)
  );

  // Edge detection on the filtered levels. The delayed copies reset to
  // the same idle levels as the filters, so the first cycles after
  // reset show no edge.
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      sel_n_d_reg <= 1'b1;
      sclk_d_reg  <= 1'b0;
    end else begin
      sel_n_d_reg <= sel_n;
      sclk_d_reg  <= sclk;
    end
  end

  assign sel_fall  = sel_n_d_reg & ~sel_n;
  assign sclk_fall = sclk_d_reg & ~sclk;

  // A frame loads once per select fall seen in power-down, and steps
  // once per serial clock fall while select stays low; a clock fall that
  // meets a select rise is dropped so that the abort wins cleanly.
  assign frame_load = (state_reg == ST_DOWN) && sel_fall;
  assign frame_step = (state_reg == ST_CONV) && sclk_fall
                      && !sel_n;

  // Next state: select high always forces power-down, from any state,
  // so an aborted frame ends at once. A frame is complete after the
  // sixteenth serial clock fall; later clock edges are ignored until
  // select rises and falls again.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_DOWN: begin
        if (sel_fall) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (sel_n) begin
          state_next = ST_DOWN;
        end else if (sclk_fall &&
                     cnt_reg == `DASR_CNT_LAST) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (sel_n) begin
          state_next = ST_DOWN;
        end
      end
      default: begin
        state_next = ST_DOWN;
      end
    endcase
  end

  // Next values of the bit counter and the frame shift register. The
  // frame is built whole at select fall, null bits on top, so every
  // later step only moves it up by one place and feeds a zero in.
  always @* begin
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    if (frame_load) begin
      cnt_next   = `DASR_CNT_RST;
      // The core delivers a two's-complement code, which is kept as is.
      shift_next = {{`DASR_NULL_BITS{1'b0}}, SAMPLE_I};
    end else if (frame_step) begin
      // Only serial clock falls move the frame on.
      cnt_next   = cnt_reg + `DASR_CNT_ONE;
      shift_next = {shift_reg[`DASR_FRAME_BITS-2:0], 1'b0};
    end
  end

  // State, bit counter and shift register, all on the system clock so
  // that the pin filters are the only place where time is crossed.
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      state_reg <= ST_DOWN;
      cnt_reg   <= `DASR_CNT_RST;
      shift_reg <= `DASR_SHIFT_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
    end
  end

  // Next values of the status outputs, decoded from the next state so
  // that each output flip-flop turns in the same cycle as the state.
  // Any code outside the three states reads as power-down.
  always @* begin
    pd_next   = 1'b1;
    busy_next = 1'b0;
    hold_next = 1'b0;
    oe_n_next = 1'b1;
    case (state_next)
      ST_DOWN: begin
        pd_next   = 1'b1;
        busy_next = 1'b0;
        hold_next = 1'b0;
        oe_n_next = 1'b1;
      end
      ST_CONV: begin
        pd_next   = 1'b0;
        busy_next = 1'b1;
        hold_next = 1'b1;
        oe_n_next = 1'b0;
      end
      ST_DONE: begin
        pd_next   = 1'b0;
        busy_next = 1'b0;
        hold_next = 1'b1;
        oe_n_next = 1'b0;
      end
      default: begin
        pd_next   = 1'b1;
        busy_next = 1'b0;
        hold_next = 1'b0;
        oe_n_next = 1'b1;
      end
    endcase
  end

  // Next value of the serial data bit. Power-down takes priority, so a
  // clock fall that meets a select rise cannot drive a bit while the
  // output enable is being withdrawn. Otherwise the top of the next
  // frame word is shown: the first null bit at select fall and each
  // later bit one serial clock fall after the one before.
  always @* begin
    data_next = SER_DATA_O;
    if (state_next == ST_DOWN) begin
      data_next = 1'b0;
    end else if (frame_load) begin
      data_next = shift_next[`DASR_FRAME_BITS-1];
    end else if (frame_step) begin
      data_next = shift_next[`DASR_FRAME_BITS-1];
    end
  end

  // Registered pin outputs; each top-level output is one flip-flop, so
  // the pins never show a decode glitch.
  always @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      SER_DATA_O      <= 1'b0;
      SER_DATA_OE_N_O <= 1'b1;
      POWER_DOWN_O    <= 1'b1;
      CONV_BUSY_O     <= 1'b0;
      SAMPLE_HOLD_O   <= 1'b0;
    end else begin
      SER_DATA_O      <= data_next;
      SER_DATA_OE_N_O <= oe_n_next;
      POWER_DOWN_O    <= pd_next;
      CONV_BUSY_O     <= busy_next;
      SAMPLE_HOLD_O   <= hold_next;
    end
  end
endmodule

// File: test/dasr_checker.sv
// Port assertions for the readout top.
// Assumes a bind to dasr_top.
module dasr_checker (
  input logic CLOCK_I,
  input logic SYS_RST_I,
  input logic CONV_SEL_N_I,
  input logic SER_CLK_I,
  input logic SER_DATA_O,
  input logic SER_DATA_OE_N_O,
  input logic POWER_DOWN_O,
  input logic CONV_BUSY_O,
  input logic SAMPLE_HOLD_O
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  // Power state follows select; frames open and close cleanly.
  a_quiet_pd: assert property (
    POWER_DOWN_O |-> SER_DATA_OE_N_O && !SER_DATA_O) else $error("pd out");
  a_sel_pd: assert property (
    CONV_SEL_N_I [*8] |-> POWER_DOWN_O) else $error("no pd");
  a_sel_run: assert property (
    !CONV_SEL_N_I [*8] |-> !POWER_DOWN_O) else $error("no run");
  a_frame_start: assert property (
    $fell(POWER_DOWN_O) |-> !$past(CONV_SEL_N_I, 3) && CONV_BUSY_O
      && SAMPLE_HOLD_O && !SER_DATA_O) else $error("bad start");
  a_data_edge: assert property (
    $changed(SER_DATA_O) && !POWER_DOWN_O |-> !$past(SER_CLK_I, 4))
    else $error("data off edge");
  a_clock_paced: assert property (
    (!SER_CLK_I && SAMPLE_HOLD_O) [*8] |-> $stable(SER_DATA_O))
    else $error("data moved");
  a_frame_end: assert property (
    $fell(CONV_BUSY_O) && !POWER_DOWN_O |-> !SER_DATA_O)
    else $error("bad end");
endmodule
bind dasr_top dasr_checker chk (.*);

// File: test/dasr_host.sv
// Host model driving select and a 400 ns serial clock.
// Assumes the bench clock; serial clock idles low.
module dasr_host (
  input  logic clk_i,
  input  logic data_i,
  input  logic oe_n_i,
  output logic sel_n_o = 1'b1,
  output logic sclk_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released line shows the inverse of the data output, which power-down holds at zero.
  wire line = oe_n_i ? ~data_i : data_i;
  // Select fall starts a conversion.
  task open;
    sel_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // Sampling sits late in the high phase to cover sync delay.
  task bits(input int n, output logic [15:0] got);
    got = 16'h0000;
    repeat (n) begin
      sclk_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      got = {got[14:0], line};
      sclk_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask
  // Select rise ends the frame.
  task close;
    sel_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

// File: test/testbench.sv
// Bench: host model reads frames and the words are checked.
// Assumes dasr_host drives select and serial clock.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1;
  logic [11:0] samp = 12'h000;
  logic [15:0] g;
  wire sel_n, sclk, dat, oe_n, pd, busy, hold;
  int bad_count = 0, n_tests = 0;
  // Clock of 50 ns period.
  always #25 clk = ~clk;
  dasr_top uut (.CLOCK_I(clk), .SYS_RST_I(rst), .CONV_SEL_N_I(sel_n),
    .SER_CLK_I(sclk), .SAMPLE_I(samp), .SER_DATA_O(dat),
    .SER_DATA_OE_N_O(oe_n), .POWER_DOWN_O(pd), .CONV_BUSY_O(busy),
    .SAMPLE_HOLD_O(hold));
  dasr_host host (.clk_i(clk), .data_i(dat), .oe_n_i(oe_n),
    .sel_n_o(sel_n), .sclk_o(sclk));
  task chk(string n, logic [15:0] e, logic [15:0] v);
    n_tests++;
    if (v !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, v);
    end
  endtask
  // Full frames over sign boundary values.
  task t_frames;
    logic [11:0] w [4];
    w = '{12'h5A3, 12'h800, 12'h7FF, 12'hFFF};
    foreach (w[i]) begin
      samp <= w[i];
      host.open();
      chk("pd", 16'h0001, {13'h0, pd, oe_n, hold});
      host.bits(16, g);
      chk("frame", {4'h0, w[i]}, g);
      chk("busy", 16'h0001, {14'h0, busy, hold});
      host.close();
      chk("idle", 16'h0006, {13'h0, pd, oe_n, hold});
    end
  endtask
  // Select rise in mid-frame, then a frame with a long clock stall.
  task t_abort_stall;
    samp <= 12'h9C6;
    host.open();
    host.bits(6, g);
    host.close();
    chk("part", 16'h0002, g);
    chk("abort", 16'h0006, {13'h0, pd, oe_n, hold});
    samp <= 12'h3E1;
    host.open();
    repeat (40) @(posedge clk);
    chk("stall", 16'h0006, {13'h0, busy, hold, dat});
    host.bits(16, g);
    chk("resume", 16'h03E1, g);
    host.close();
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    t_frames();
    t_abort_stall();
    stop_test();
  end
  // Watchdog at several times the expected run of some 860 clocks.
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
endmodule
